// ==== qsmp_pkg.sv ====
package qsmp_pkg;

   // ==========================================================
   // register byte offsets (aligned 32-bit words)
   localparam logic [7:0] OFS_PIN_DIR = 8'h00;
   localparam logic [7:0] OFS_PIN_DATA = 8'h04;
   localparam logic [7:0] OFS_PIN_FUNC = 8'h08;
   localparam logic [7:0] OFS_MODE = 8'h0c;
   localparam logic [7:0] OFS_RUN = 8'h10;
   localparam logic [7:0] OFS_QPTR = 8'h14;
   localparam logic [7:0] OFS_DEBUG = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1c;
   localparam logic [7:0] OFS_TXQ = 8'h40;
   localparam logic [7:0] OFS_RXQ = 8'h80;
   localparam logic [7:0] OFS_CMDQ = 8'hc0;

   // ==========================================================
   // serial_mode_control fields
   localparam int MODE_MASTER = 15;
   localparam int MODE_WIRED_OR = 14;
   localparam int MODE_BITS_LSB = 10;
   localparam int MODE_CLOCK_POLARITY = 9;
   localparam int MODE_CLOCK_PHASE = 8;
   localparam int MODE_BAUD_LSB = 0;
   // run_and_delay_control fields
   localparam int RUN_ENABLE = 15;
   localparam int RUN_PRE_LSB = 8;
   localparam int RUN_POST_LSB = 0;
   // queue_pointer_control fields
   localparam int QP_FIE = 15;
   localparam int QP_WRAP_ENABLE = 14;
   localparam int QP_WRAP_TARGET = 13;
   localparam int QP_END_LSB = 8;
   localparam int QP_START_LSB = 0;
   // queue_status fields
   localparam int STAT_FIN = 7;
   localparam int STAT_CPTR_LSB = 0;

   // ==========================================================
   // reset values
   localparam logic [15:0] MODE_RESET = 16'h0004;
   localparam logic [15:0] RUN_RESET = 16'h0000;
   localparam logic [15:0] QPTR_RESET = 16'h0000;
   localparam logic [7:0] PIN_RESET = 8'h00;

   // ==========================================================
   // port pin positions
   localparam int PIN_MISO = 0;
   localparam int PIN_MOSI = 1;
   localparam int PIN_SCK = 2;
   localparam int PIN_PCS_LSB = 3;

   // ==========================================================
   // timing and lengths, in system clock cycles and bits
   localparam logic [7:0] MIN_HALF_CYCLES = 8'h02;
   localparam int POST_UNIT_SHIFT = 5;
   localparam logic [4:0] DEFAULT_LEN = 5'h08;
   localparam logic [4:0] MAX_LEN = 5'h10;

   // ==========================================================
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // types
   typedef struct packed {
      logic keep_select;
      logic length_select_en;
      logic post_transfer_delay_en;
      logic pre_clock_delay_en;
      logic [3:0] periph_select_n;
   } qsmp_cmd_s;

   typedef enum logic [2:0] {
      QSMP_IDLE = 3'h0,
      QSMP_LOAD = 3'h1,
      QSMP_SHIFT = 3'h2,
      QSMP_HOLD = 3'h3,
      QSMP_POST = 3'h4
   } qsmp_state_e;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } qsmp_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } qsmp_axi_rsp_s;

endpackage

// ==== qsmp_top.sv ====
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module qsmp_top #(
   parameter int QUEUE_DEPTH = 16
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // register bus
   input wire qsmp_pkg::qsmp_axi_req_s axi_req,
   output qsmp_pkg::qsmp_axi_rsp_s axi_rsp,
   // port pins
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe_n,
   // completion interrupt
   output logic finish_irq
);

   // ==========================================================
   // elaboration check
   initial begin
      if (QUEUE_DEPTH != 16) begin
         $error("qsmp_top: queue decode serves exactly sixteen entries");
      end
   end

   // ==========================================================
   // state record
   typedef struct packed {
      qsmp_pkg::qsmp_state_e st;
      logic [QUEUE_DEPTH-1:0][15:0] txq;
      logic [QUEUE_DEPTH-1:0][15:0] rxq;
      logic [QUEUE_DEPTH-1:0][7:0] cmdq;
      logic [7:0] ddr;
      logic [7:0] pdr;
      logic [7:0] par;
      logic [7:0] dbg;
      logic [15:0] mode;
      logic [15:0] rdc;
      logic [15:0] qpc;
      logic fin;
      logic [3:0] cptr;
      logic [3:0] ptr;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [12:0] cnt;
      logic [4:0] edges;
      logic [4:0] len;
      logic [15:0] sh;
      logic [15:0] rxsh;
      logic sck;
      logic mosi;
      logic [3:0] pcs;
      logic keep;
      logic post_en;
      logic [7:0] pin_out;
      logic [7:0] pin_oe_n;
      logic irq;
      logic aw_held;
      logic [7:0] awaddr_h;
      logic w_held;
      logic [31:0] wdata_h;
      logic [3:0] wstrb_h;
      qsmp_pkg::qsmp_axi_rsp_s rsp;
   } qsmp_regs_s;

   qsmp_regs_s s;
   qsmp_regs_s n;

   // ==========================================================
   // helpers
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] b);
      merge16 = old;
      if (b[0]) begin
         merge16[7:0] = d[7:0];
      end
      if (b[1]) begin
         merge16[15:8] = d[15:8];
      end
   endfunction

   // length field 0 means 16; values under 8 fall back to 8
   function automatic logic [4:0] len_of(input logic [3:0] bits, input logic lse);
      if (!lse) begin
         len_of = qsmp_pkg::DEFAULT_LEN;
      end else if (bits == 4'h0) begin
         len_of = qsmp_pkg::MAX_LEN;
      end else if ({1'b0, bits} < qsmp_pkg::DEFAULT_LEN) begin
         len_of = qsmp_pkg::DEFAULT_LEN;
      end else begin
         len_of = {1'b0, bits};
      end
   endfunction

   function automatic logic in_region(input logic [7:0] a, input logic [7:0] base);
      in_region = (a[7:6] == base[7:6]);
   endfunction

   // ==========================================================
   // decoded views of the current state
   qsmp_pkg::qsmp_cmd_s cur_cmd;
   logic run_ok;
   logic [7:0] baud;
   logic [7:0] half;
   logic [3:0] start_ptr;
   logic [3:0] end_ptr;
   logic [3:0] def_cs;
   logic xfer_done;
   logic at_end;
   logic wr_go;
   logic clr_fin;

   assign cur_cmd = qsmp_pkg::qsmp_cmd_s'(s.cmdq[s.ptr]);
   assign run_ok = s.rdc[qsmp_pkg::RUN_ENABLE] & s.mode[qsmp_pkg::MODE_MASTER];
   assign baud = s.mode[qsmp_pkg::MODE_BAUD_LSB +: 8];
   // a divider below two would beat the quarter-rate ceiling
   assign half = (baud < qsmp_pkg::MIN_HALF_CYCLES) ? qsmp_pkg::MIN_HALF_CYCLES : baud;
   assign start_ptr = s.qpc[qsmp_pkg::QP_START_LSB +: 4];
   assign end_ptr = s.qpc[qsmp_pkg::QP_END_LSB +: 4];
   assign def_cs = s.pdr[qsmp_pkg::PIN_PCS_LSB +: 4];
   assign xfer_done = (s.st == qsmp_pkg::QSMP_HOLD) && run_ok && (s.cnt <= 13'h0001);
   assign at_end = (s.ptr == end_ptr);
   assign wr_go = s.aw_held & s.w_held & ~s.rsp.bvalid;
   assign clr_fin = wr_go && (s.awaddr_h == qsmp_pkg::OFS_STATUS) && s.wstrb_h[0] && s.wdata_h[qsmp_pkg::STAT_FIN];

   // ==========================================================
   // next-state logic
   always_comb begin
      logic [31:0] rd;
      logic rd_ok;
      logic fin_set;
      logic [4:0] ln;
      logic [7:0] ser;
      logic drive;
      logic val;
      logic [3:0] idx;
      rd = 32'h0000_0000;
      rd_ok = 1'b1;
      fin_set = 1'b0;
      ln = qsmp_pkg::DEFAULT_LEN;
      ser = 8'h00;
      drive = 1'b0;
      val = 1'b0;
      idx = 4'h0;
      n = s;

      // pins pass two flops before any logic looks at them
      n.sync1 = pin_in;
      n.sync2 = s.sync1;

      // queue engine; losing run or master aborts at once
      if (s.st != qsmp_pkg::QSMP_IDLE && !run_ok) begin
         n.st = qsmp_pkg::QSMP_IDLE;
         n.sck = s.mode[qsmp_pkg::MODE_CLOCK_POLARITY];
      end else begin
         case (s.st)
            qsmp_pkg::QSMP_IDLE: begin
               n.sck = s.mode[qsmp_pkg::MODE_CLOCK_POLARITY];
               if (!s.keep) begin
                  n.pcs = def_cs;
               end
               if (run_ok) begin
                  n.ptr = start_ptr;
                  n.st = qsmp_pkg::QSMP_LOAD;
               end
            end
            qsmp_pkg::QSMP_LOAD: begin
               ln = len_of(s.mode[qsmp_pkg::MODE_BITS_LSB +: 4], cur_cmd.length_select_en);
               n.len = ln;
               n.pcs = cur_cmd.periph_select_n;
               n.keep = cur_cmd.keep_select;
               n.post_en = cur_cmd.post_transfer_delay_en;
               n.sh = s.txq[s.ptr] << (qsmp_pkg::MAX_LEN - ln);
               n.rxsh = 16'h0000;
               n.edges = 5'h00;
               // lead time runs from the cycle the selects appear
               if (cur_cmd.pre_clock_delay_en) begin
                  n.cnt = {6'h00, s.rdc[qsmp_pkg::RUN_PRE_LSB +: 7]};
               end else begin
                  n.cnt = {5'h00, half};
               end
               if (!s.mode[qsmp_pkg::MODE_CLOCK_PHASE]) begin
                  n.mosi = n.sh[15];
                  n.sh = {n.sh[14:0], 1'b0};
               end
               n.st = qsmp_pkg::QSMP_SHIFT;
            end
            qsmp_pkg::QSMP_SHIFT: begin
               if (s.cnt > 13'h0001) begin
                  n.cnt = s.cnt - 13'h0001;
               end else begin
                  n.sck = ~s.sck;
                  n.cnt = {5'h00, half};
                  n.edges = s.edges + 5'h01;
                  // leading edge samples for phase 0, launches for phase 1
                  if (s.edges[0] == s.mode[qsmp_pkg::MODE_CLOCK_PHASE]) begin
                     n.rxsh = {s.rxsh[14:0], s.sync2[qsmp_pkg::PIN_MISO]};
                  end else begin
                     n.mosi = s.sh[15];
                     n.sh = {s.sh[14:0], 1'b0};
                  end
                  if (s.edges == 5'({s.len, 1'b0} - 6'h01)) begin
                     n.st = qsmp_pkg::QSMP_HOLD;
                  end
               end
            end
            qsmp_pkg::QSMP_HOLD: begin
               if (s.cnt > 13'h0001) begin
                  n.cnt = s.cnt - 13'h0001;
               end else begin
                  n.rxq[s.ptr] = s.rxsh;
                  n.cptr = s.ptr;
                  if (!s.keep) begin
                     n.pcs = def_cs;
                  end
                  if (at_end) begin
                     fin_set = 1'b1;
                     if (s.qpc[qsmp_pkg::QP_WRAP_ENABLE]) begin
                        n.ptr = s.qpc[qsmp_pkg::QP_WRAP_TARGET] ? start_ptr : 4'h0;
                     end else begin
                        n.rdc[qsmp_pkg::RUN_ENABLE] = 1'b0;
                     end
                  end else begin
                     n.ptr = s.ptr + 4'h1;
                  end
                  if (s.post_en) begin
                     n.cnt = 13'({s.rdc[qsmp_pkg::RUN_POST_LSB +: 8], 5'h00});
                  end else begin
                     n.cnt = 13'h0001;
                  end
                  n.st = qsmp_pkg::QSMP_POST;
               end
            end
            qsmp_pkg::QSMP_POST: begin
               if (s.cnt > 13'h0001) begin
                  n.cnt = s.cnt - 13'h0001;
               end else begin
                  n.st = qsmp_pkg::QSMP_LOAD;
               end
            end
            default: begin
               n.st = qsmp_pkg::QSMP_IDLE;
            end
         endcase
      end

      // write channel: address and data taken in either order
      if (axi_req.awvalid && s.rsp.awready) begin
         n.aw_held = 1'b1;
         n.awaddr_h = {axi_req.awaddr[7:2], 2'h0};
      end
      if (axi_req.wvalid && s.rsp.wready) begin
         n.w_held = 1'b1;
         n.wdata_h = axi_req.wdata;
         n.wstrb_h = axi_req.wstrb;
      end
      if (s.rsp.bvalid && axi_req.bready) begin
         n.rsp.bvalid = 1'b0;
      end
      // software writes land after the engine so a rewrite of run wins
      if (wr_go) begin
         n.aw_held = 1'b0;
         n.w_held = 1'b0;
         n.rsp.bvalid = 1'b1;
         n.rsp.bresp = qsmp_pkg::RESP_OKAY;
         idx = s.awaddr_h[5:2];
         if (s.awaddr_h == qsmp_pkg::OFS_PIN_DIR) begin
            n.ddr = 8'(merge16({8'h00, s.ddr}, s.wdata_h, s.wstrb_h));
         end else if (s.awaddr_h == qsmp_pkg::OFS_PIN_DATA) begin
            n.pdr = 8'(merge16({8'h00, s.pdr}, s.wdata_h, s.wstrb_h));
         end else if (s.awaddr_h == qsmp_pkg::OFS_PIN_FUNC) begin
            n.par = 8'(merge16({8'h00, s.par}, s.wdata_h, s.wstrb_h));
         end else if (s.awaddr_h == qsmp_pkg::OFS_MODE) begin
            n.mode = merge16(s.mode, s.wdata_h, s.wstrb_h);
         end else if (s.awaddr_h == qsmp_pkg::OFS_RUN) begin
            n.rdc = merge16(s.rdc, s.wdata_h, s.wstrb_h);
         end else if (s.awaddr_h == qsmp_pkg::OFS_QPTR) begin
            n.qpc = merge16(s.qpc, s.wdata_h, s.wstrb_h);
         end else if (s.awaddr_h == qsmp_pkg::OFS_DEBUG) begin
            n.dbg = 8'(merge16({8'h00, s.dbg}, s.wdata_h, s.wstrb_h));
         end else if (s.awaddr_h == qsmp_pkg::OFS_STATUS) begin
            if (clr_fin) begin
               n.fin = 1'b0;
            end
         end else if (in_region(s.awaddr_h, qsmp_pkg::OFS_TXQ)) begin
            n.txq[idx] = merge16(s.txq[idx], s.wdata_h, s.wstrb_h);
         end else if (in_region(s.awaddr_h, qsmp_pkg::OFS_CMDQ)) begin
            n.cmdq[idx] = 8'(merge16({8'h00, s.cmdq[idx]}, s.wdata_h, s.wstrb_h));
         end else begin
            n.rsp.bresp = qsmp_pkg::RESP_SLVERR;
         end
      end
      // a completion in the clearing cycle keeps the flag set
      if (fin_set) begin
         n.fin = 1'b1;
      end
      n.rsp.awready = ~n.aw_held;
      n.rsp.wready = ~n.w_held;

      // read channel, one outstanding answer
      if (s.rsp.rvalid && axi_req.rready) begin
         n.rsp.rvalid = 1'b0;
      end
      if (axi_req.arvalid && s.rsp.arready) begin
         idx = axi_req.araddr[5:2];
         if ({axi_req.araddr[7:2], 2'h0} == qsmp_pkg::OFS_PIN_DIR) begin
            rd = {24'h0, s.ddr};
         end else if ({axi_req.araddr[7:2], 2'h0} == qsmp_pkg::OFS_PIN_DATA) begin
            rd = {24'h0, (s.ddr & s.pdr) | (~s.ddr & s.sync2)};
         end else if ({axi_req.araddr[7:2], 2'h0} == qsmp_pkg::OFS_PIN_FUNC) begin
            rd = {24'h0, s.par};
         end else if ({axi_req.araddr[7:2], 2'h0} == qsmp_pkg::OFS_MODE) begin
            rd = {16'h0, s.mode};
         end else if ({axi_req.araddr[7:2], 2'h0} == qsmp_pkg::OFS_RUN) begin
            rd = {16'h0, s.rdc};
         end else if ({axi_req.araddr[7:2], 2'h0} == qsmp_pkg::OFS_QPTR) begin
            rd = {16'h0, s.qpc};
         end else if ({axi_req.araddr[7:2], 2'h0} == qsmp_pkg::OFS_DEBUG) begin
            rd = {24'h0, s.dbg};
         end else if ({axi_req.araddr[7:2], 2'h0} == qsmp_pkg::OFS_STATUS) begin
            rd[qsmp_pkg::STAT_FIN] = s.fin;
            rd[qsmp_pkg::STAT_CPTR_LSB +: 4] = s.cptr;
         end else if (in_region(axi_req.araddr, qsmp_pkg::OFS_TXQ)) begin
            rd = {16'h0, s.txq[idx]};
         end else if (in_region(axi_req.araddr, qsmp_pkg::OFS_RXQ)) begin
            rd = {16'h0, s.rxq[idx]};
         end else if (in_region(axi_req.araddr, qsmp_pkg::OFS_CMDQ)) begin
            rd = {24'h0, s.cmdq[idx]};
         end else begin
            rd_ok = 1'b0;
         end
         n.rsp.rvalid = 1'b1;
         n.rsp.rdata = rd;
         n.rsp.rresp = rd_ok ? qsmp_pkg::RESP_OKAY : qsmp_pkg::RESP_SLVERR;
      end
      n.rsp.arready = ~n.rsp.rvalid;

      // pin drivers; miso and the spare pin carry no serial output
      ser = n.pdr;
      ser[qsmp_pkg::PIN_MOSI] = n.mosi;
      ser[qsmp_pkg::PIN_SCK] = n.sck;
      ser[qsmp_pkg::PIN_PCS_LSB +: 4] = n.pcs;
      for (int i = 0; i < 8; i++) begin
         val = n.par[i] ? ser[i] : n.pdr[i];
         drive = n.ddr[i];
         // as slave this block never drives the serial pins
         if (n.par[i] && !n.mode[qsmp_pkg::MODE_MASTER]) begin
            drive = 1'b0;
         end
         if (n.par[i] && n.mode[qsmp_pkg::MODE_WIRED_OR] && val) begin
            drive = 1'b0;
         end
         n.pin_out[i] = val;
         n.pin_oe_n[i] = ~drive;
      end
      n.irq = n.fin & n.qpc[qsmp_pkg::QP_FIE];
   end

   // ==========================================================
   // state register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
         s.st <= qsmp_pkg::QSMP_IDLE;
         s.mode <= qsmp_pkg::MODE_RESET;
         s.rdc <= qsmp_pkg::RUN_RESET;
         s.qpc <= qsmp_pkg::QPTR_RESET;
         s.ddr <= qsmp_pkg::PIN_RESET;
         s.pin_oe_n <= 8'hff;
      end else begin
         s <= n;
      end
   end

   assign axi_rsp = s.rsp;
   assign pin_out = s.pin_out;
   assign pin_oe_n = s.pin_oe_n;
   assign finish_irq = s.irq;

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   // idle clock follows a polarity write one cycle later
   chk_sck_idle_level: assert property ((s.st == qsmp_pkg::QSMP_IDLE) |-> (s.sck == $past(s.mode[qsmp_pkg::MODE_CLOCK_POLARITY])))
      else $error("serial clock not at idle level");
   chk_sck_quarter_rate: assert property ($changed(s.sck) && s.st != qsmp_pkg::QSMP_IDLE |=> !$changed(s.sck))
      else $error("serial clock toggled on consecutive cycles");
   chk_cs_at_start: assert property ((s.st == qsmp_pkg::QSMP_LOAD) && run_ok |=> (s.pcs == $past(cur_cmd.periph_select_n)))
      else $error("entry select pattern not driven");
   chk_default_length: assert property ((s.st == qsmp_pkg::QSMP_LOAD) && run_ok && !cur_cmd.length_select_en
      |=> (s.len == qsmp_pkg::DEFAULT_LEN))
      else $error("default length is not eight");
   chk_run_self_clear: assert property (xfer_done && at_end && !s.qpc[qsmp_pkg::QP_WRAP_ENABLE] && !wr_go
      |=> !s.rdc[qsmp_pkg::RUN_ENABLE] ##1 (s.st == qsmp_pkg::QSMP_IDLE)[*2])
      else $error("run enable not cleared after last entry");
   chk_wrap_point: assert property (xfer_done && at_end && s.qpc[qsmp_pkg::QP_WRAP_ENABLE]
      |=> (s.ptr == ($past(s.qpc[qsmp_pkg::QP_WRAP_TARGET]) ? $past(start_ptr) : 4'h0)))
      else $error("wrong wrap entry");
   chk_completed_ptr: assert property (xfer_done |=> (s.cptr == $past(s.ptr)) && (s.rxq[s.cptr] == $past(s.rxsh)))
      else $error("completed pointer or receive word wrong");
   chk_finish_sticky: assert property (s.fin && !clr_fin |=> s.fin)
      else $error("finished flag dropped without clear");
   chk_finish_set: assert property (xfer_done && at_end |=> s.fin && (s.cptr == $past(end_ptr)))
      else $error("finished flag not set at end entry");
   chk_irq_follows: assert property (s.irq == (s.fin && s.qpc[qsmp_pkg::QP_FIE]))
      else $error("interrupt disagrees with flag and enable");
   chk_input_undriven: assert property ((~s.ddr & ~s.pin_oe_n) == 8'h00)
      else $error("input pin driven");

   cov_wrap: cover property (xfer_done && at_end && s.qpc[qsmp_pkg::QP_WRAP_ENABLE]);
   cov_stop: cover property (xfer_done && at_end && !s.qpc[qsmp_pkg::QP_WRAP_ENABLE]);
   cov_long_word: cover property ((s.st == qsmp_pkg::QSMP_HOLD) && (s.len == qsmp_pkg::MAX_LEN));
   cov_lead_delay: cover property ((s.st == qsmp_pkg::QSMP_LOAD) && run_ok && cur_cmd.pre_clock_delay_en);

endmodule

// ==== qsmp_periph.sv ====
`timescale 1ns/100ps
// ====================
// far-side peripheral, idle-low or idle-high clock: samples mosi on rise, shifts its reply out msb first
module qsmp_periph #(
   parameter logic [15:0] REPLY = 16'hb38d
) (
   // serial pins
   input wire logic sck,
   input wire logic mosi,
   input wire logic [3:0] sel_n,
   output logic miso,
   // capture
   output logic [15:0] got,
   output logic [3:0] got_sel
);
   logic [15:0] sh = 16'h0;
   logic lst = 1'b0;
   logic first = 1'b0;
   logic skip = 1'b0;
   logic sel_q = 1'b1;
   logic sck_q = 1'b0;
   // released line shows the inverse of its last bit, so a stale bit never passes
   assign miso = sel_n[0] ? ~lst : sh[15];
   // one process owns all state; with an idle-high clock the first fall only launches, so it shifts nothing
   always @(sel_n[0], sck) begin
      if (!sel_n[0] && sel_q) begin
         sh = REPLY;
         got = 16'h0;
         first = 1'b1;
         skip = sck;
      end else if (!sel_n[0] && sck && !sck_q) begin
         got = {got[14:0], mosi};
         if (first) got_sel = sel_n;
         first = 1'b0;
      end else if (!sel_n[0] && !sck && sck_q) begin
         if (skip) begin
            skip = 1'b0;
         end else begin
            lst = sh[15];
            sh = sh << 1;
         end
      end
      sel_q = sel_n[0];
      sck_q = sck;
   end
endmodule

// ==== test_queued_serial_master_port.sv ====
`timescale 1ns/100ps
// ====================
// bench: random single-entry queues against the peripheral model
module test_queued_serial_master_port;
   localparam logic [15:0] REPLY = 16'hb38d;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   qsmp_pkg::qsmp_axi_req_s req = '0;
   qsmp_pkg::qsmp_axi_rsp_s rsp;
   logic [7:0] pin_out, oe_n, pw;
   logic miso, irq;
   logic [15:0] got;
   logic [3:0] got_sel;
   logic [31:0] seed = 32'h58;
   logic [31:0] rd;
   logic [1:0] resp;
   int fails = 0;
   int comparisons = 0;
   // undriven pins are pulled high, except pin 0, which carries the peripheral's miso
   assign pw = (oe_n & {7'h7f, miso}) | (~oe_n & pin_out);
   // clock
   always #5 mclk = ~mclk;
   qsmp_top qsmp_top_i (.mclk(mclk), .rst_b(rst_b), .axi_req(req), .axi_rsp(rsp), .pin_in(pw),
      .pin_out(pin_out), .pin_oe_n(oe_n), .finish_irq(irq));
   qsmp_periph #(.REPLY(REPLY)) qsmp_periph_i (.sck(pw[2]), .mosi(pw[1]), .sel_n(pw[6:3]), .miso(miso),
      .got(got), .got_sel(got_sel));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // low n bits of a word
   function automatic logic [15:0] lo(input logic [15:0] v, input int n);
      return v & 16'((17'h1 << n) - 17'h1);
   endfunction
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // bus write: address and data offered together, each dropped once taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      req <= {1'b1, a, 1'b1, d, 4'hf, 1'b1, 10'h0};
      do begin
         @(posedge mclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid);
      req.bready <= 1'b0;
      resp = rsp.bresp;
   endtask
   task rdr(input logic [7:0] a);
      @(posedge mclk);
      req <= {47'h0, 1'b1, a, 1'b1};
      do begin
         @(posedge mclk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid);
      req.rready <= 1'b0;
      rd = rsp.rdata;
      resp = rsp.rresp;
   endtask
   task end_sim();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog, well beyond ten short transfers
   initial begin
      #400000;
      fails++;
      end_sim();
   end
   // ====================
   // main sequence
   initial begin
      int len;
      logic [15:0] tx;
      logic [7:0] cmd;
      logic [3:0] e;
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      rdr(qsmp_pkg::OFS_MODE);
      chk("mode reset", 32'h4, rd);
      rdr(8'h30);
      chk("unmapped", 32'(qsmp_pkg::RESP_SLVERR), 32'(resp));
      wr(qsmp_pkg::OFS_PIN_FUNC, 32'hff);
      wr(qsmp_pkg::OFS_PIN_DIR, 32'h7e);
      wr(qsmp_pkg::OFS_PIN_DATA, 32'h78);
      rdr(qsmp_pkg::OFS_PIN_DATA);
      chk("pin data", 32'hf8, rd & 32'hfe);
      for (int t = 0; t < 10; t++) begin
         rd = rnd();
         tx = rd[15:0];
         len = 8 + rd[19:16] % 9;
         cmd = {1'b0, rd[20], rd[21], rd[22], rd[25:23], 1'b0};
         e = rd[29:26];
         // first two runs pin the length at both ends of its range
         if (t < 2) len = 8 + 8 * t;
         if (t < 2) cmd[6] = 1'b1;
         // the last run keeps its selects so the held pattern can be seen
         if (t == 9) cmd[7] = 1'b1;
         // bit 30 picks idle-low leading sample or idle-high trailing sample
         wr(qsmp_pkg::OFS_MODE, 32'h8004 | 32'((len & 15) << 10) | {22'h0, {2{rd[30]}}, 8'h00});
         wr(qsmp_pkg::OFS_TXQ + {2'h0, e, 2'h0}, {16'h0, tx});
         wr(qsmp_pkg::OFS_CMDQ + {2'h0, e, 2'h0}, {24'h0, cmd});
         wr(qsmp_pkg::OFS_QPTR, {16'h0, 4'h8, e, 4'h0, e});
         wr(qsmp_pkg::OFS_RUN, 32'h8402);
         do rdr(qsmp_pkg::OFS_RUN); while (rd[15]);
         if (!cmd[6]) len = 8;
         chk("mosi word", lo(tx, len), got);
         chk("selects", cmd[3:0], got_sel);
         chk("held selects", cmd[7] ? cmd[3:0] : 4'hf, pw[6:3]);
         rdr(qsmp_pkg::OFS_RXQ + {2'h0, e, 2'h0});
         chk("rx word", REPLY >> (16 - len), rd);
         rdr(qsmp_pkg::OFS_STATUS);
         chk("status", {24'h0, 4'h8, e}, rd);
         chk("irq", 32'h1, {31'h0, irq});
         wr(qsmp_pkg::OFS_STATUS, 32'h80);
         rdr(qsmp_pkg::OFS_STATUS);
         chk("status cleared", {28'h0, e}, rd);
      end
      // wrap corner: entries 2 and 3 loop back to entry 0 or to the start entry
      rd = rnd();
      e = {3'h0, rd[0]};
      wr(qsmp_pkg::OFS_QPTR, {16'h0, 2'h1, e[0], 13'h0302});
      wr(qsmp_pkg::OFS_RUN, 32'h8000);
      do rdr(qsmp_pkg::OFS_STATUS); while (!rd[7]);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(qsmp_pkg::OFS_STATUS, 32'h80);
      do rdr(qsmp_pkg::OFS_STATUS); while (rd[3:0] == 4'h3);
      chk("wrap entry", e[0] ? 32'h2 : 32'h0, rd & 32'hf);
      // dropping wrap lets the queue run out at the end entry and stop by itself
      wr(qsmp_pkg::OFS_QPTR, 32'h0302);
      do rdr(qsmp_pkg::OFS_RUN); while (rd[15]);
      rdr(qsmp_pkg::OFS_STATUS);
      chk("stop entry", 32'h83, rd);
      end_sim();
   end
endmodule
